//--- fpc_backplane_model.sv
// Purpose: Backplane reset line and processor interrupt intake.
// Assumes: The reset line has a pull-up on the backplane.
// Notes: Counts each new abort request once.
`timescale 1ns/10ps
`default_nettype none
// ====================
// Model
// ====================
module fpc_backplane_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic sysreset_n_o,
   input wire logic sysreset_oe,
   input wire logic abort_irq,
   output logic sysreset_wire_n,
   output logic [7:0] irq_events
);
   logic irq_d_reg;
   // A released line floats up to the pull-up level.
   assign sysreset_wire_n = sysreset_oe ? sysreset_n_o : 1'b1;
   // The processor sees a request on its rising level.
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_d_reg <= 1'b0;
         irq_events <= 8'h00;
      end else begin
         irq_d_reg <= abort_irq;
         if (abort_irq && !irq_d_reg) begin
            irq_events <= irq_events + 8'h01;
         end
      end
   end
endmodule // fpc_backplane_model
`default_nettype wire

//--- fpc_defines.svh
// Purpose: Constants for the front panel control and indicator block.
// Assumes: A 250 MHz reference clock.
// Notes: Times are in microseconds; cycle counts derive from them.
`ifndef FPC_DEFINES_SVH
`define FPC_DEFINES_SVH

// ==========================================================================
// Timing
// ==========================================================================
`define FPC_CLK_MHZ 250
`define FPC_DEBOUNCE_US 10000
`define FPC_DEBOUNCE_CYC (`FPC_DEBOUNCE_US * `FPC_CLK_MHZ)
`define FPC_RST_PULSE_US 200000
`define FPC_RST_PULSE_CYC (`FPC_RST_PULSE_US * `FPC_CLK_MHZ)
`define FPC_STRETCH_US 50000
`define FPC_STRETCH_CYC (`FPC_STRETCH_US * `FPC_CLK_MHZ)

// ==========================================================================
// Register map
// ==========================================================================
`define FPC_CTRL_OFS 8'h00
`define FPC_STATUS_OFS 8'h04
`define FPC_CTRL_SYSRST_BIT 0
`define FPC_CTRL_ABTEN_BIT 1
`define FPC_CTRL_RST_VAL 2'h2
`define FPC_ST_ABORT_PEND_BIT 0
`define FPC_ST_ABORT_SW_BIT 1
`define FPC_ST_SYSCTL_BIT 2
`define FPC_ST_RST_ACTIVE_BIT 3
`define FPC_ST_LED_LSB 8
`define FPC_NUM_ACT 4
`endif

//--- fpc_front_panel.sv
// Purpose: Front panel switches, board reset generation and status LEDs.
// Assumes: All inputs are synchronous to REF_CLK; buttons are active low.
// Notes: Registers are reached over a classic Wishbone slave.
//
// Local design decisions: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "fpc_defines.svh"

// ==========================================================================
// Module
// ==========================================================================
// Contract
// - A press of the abort button raises an interrupt to the processor.
// - The abort event fires on a debounced edge, not on the level.
// - A reset button press puts every onboard device into reset.
// - The backplane system reset is driven only when system controller.
// - System reset comes from button, power-up, watchdog or software.
// - The fault LED lights whenever a board fault is detected.
// - The halt LED lights whenever the processor is halted.
// - The run LED shows any local bus cycle in progress.
// - The system controller LED lights while the board has that role.
// - The LAN LED lights while the Ethernet controller is bus master.
// - The SCSI LED lights while the SCSI controller is bus master.
// - The VME LED lights on VME master cycles or slave accesses.
module fpc_front_panel #(
   parameter int unsigned DEBOUNCE_CYC = `FPC_DEBOUNCE_CYC,
   parameter int unsigned RST_PULSE_CYC = `FPC_RST_PULSE_CYC,
   parameter int unsigned STRETCH_CYC = `FPC_STRETCH_CYC
) (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   // Wishbone slave.
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   // Front panel buttons, low while pressed.
   input wire logic ABORT_BTN_N,
   input wire logic RESET_BTN_N,
   // Board status inputs.
   input wire logic SYS_CTRL_ROLE,
   input wire logic WDOG_EXPIRED,
   input wire logic BOARD_FAULT,
   input wire logic CPU_HALTED,
   input wire logic LOCAL_CYCLE,
   input wire logic LAN_MASTER,
   input wire logic SCSI_MASTER,
   input wire logic VME_MASTER_CYCLE,
   input wire logic VME_SLAVE_ACCESS,
   input wire logic FUSE_OK,
   // Processor interrupt and reset outputs.
   output logic ABORT_IRQ,
   output logic BOARD_RST,
   output logic SYSRESET_N_O,
   output logic SYSRESET_OE,
   // LEDs, high to light.
   output logic BOARD_FAULT_LED,
   output logic CPU_HALT_LED,
   output logic LOCAL_CYCLE_LED,
   output logic SYS_CONTROLLER_LED,
   output logic LAN_LED,
   output logic FUSE_LED,
   output logic SCSI_LED,
   output logic VME_LED
);

   // =======================================================================
   // Parameter checks
   // =======================================================================
   // Counts below one cycle cannot be served by the counters.
   generate
      if (DEBOUNCE_CYC < 1 || RST_PULSE_CYC < 1 || STRETCH_CYC < 1) begin : g_chk
         $error("fpc_front_panel: every count must be at least one cycle.");
      end
   endgenerate

   // =======================================================================
   // Declarations
   // =======================================================================
   logic wb_req;
   logic wb_wr;
   logic ack_reg;
   logic [31:0] rdata_reg;
   logic [1:0] ctrl_reg;
   logic abort_pend_reg;
   logic abort_irq_reg;
   logic [1:0] btn_raw;
   logic [1:0] btn_stable_reg;
   logic [31:0] deb_cnt_reg [2];
   logic abort_prev_reg;
   logic reset_prev_reg;
   logic abort_press;
   logic reset_press;
   logic reset_held;
   logic sw_rst_req;
   logic rst_start;
   logic power_up_reg;
   fpc_pkg::fpc_rst_state_e rst_state_reg;
   logic [31:0] rst_cnt_reg;
   logic board_rst_reg;
   logic sysreset_oe_reg;
   logic [`FPC_NUM_ACT-1:0] act_raw;
   logic [`FPC_NUM_ACT-1:0] act_led_reg;
   logic [31:0] act_cnt_reg [`FPC_NUM_ACT];
   logic fault_led_reg;
   logic halt_led_reg;
   logic sys_controller_led_led_reg;
   logic fuse_led_reg;
   logic [31:0] status_word;

   // =======================================================================
   // Wishbone slave
   // =======================================================================
   // A request is answered one cycle after it is seen; the answer stands
   // for one cycle, and a write takes effect at the edge that ack is seen.
   assign wb_req = WB_CYC_I & WB_STB_I;
   assign wb_wr = wb_req & WB_WE_I & ack_reg;

   // Acknowledge generation, one cycle per request.
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= wb_req & ~ack_reg;
      end
   end

   // Read data is captured together with the acknowledge.
   always_ff @(posedge REF_CLK) begin
      rdata_reg <= 32'h0000_0000; // Zero outside the ack and when unmapped.
      if (!SYS_RST && wb_req && !ack_reg && !WB_WE_I) begin
         if ({WB_ADR_I[7:2], 2'b00} == `FPC_CTRL_OFS) begin
            rdata_reg <= {30'h0000_0000, ctrl_reg};
         end else if ({WB_ADR_I[7:2], 2'b00} == `FPC_STATUS_OFS) begin
            rdata_reg <= status_word;
         end
      end
   end

   // Status word seen by software.
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`FPC_ST_ABORT_PEND_BIT] = abort_pend_reg;
      status_word[`FPC_ST_ABORT_SW_BIT] = ~btn_stable_reg[0];
      status_word[`FPC_ST_SYSCTL_BIT] = SYS_CTRL_ROLE;
      status_word[`FPC_ST_RST_ACTIVE_BIT] = board_rst_reg;
      status_word[`FPC_ST_LED_LSB +: 8] = {VME_LED, SCSI_LED, FUSE_LED,
         LAN_LED, SYS_CONTROLLER_LED, LOCAL_CYCLE_LED, CPU_HALT_LED,
         BOARD_FAULT_LED};
   end

   // Control register; the software reset bit clears once its pulse starts.
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         ctrl_reg <= `FPC_CTRL_RST_VAL;
      end else if (wb_wr && WB_SEL_I[0] &&
                   {WB_ADR_I[7:2], 2'b00} == `FPC_CTRL_OFS) begin
         ctrl_reg <= WB_DAT_I[1:0];
      end else if (rst_start) begin
         ctrl_reg[`FPC_CTRL_SYSRST_BIT] <= 1'b0;
      end
   end

   assign sw_rst_req = ctrl_reg[`FPC_CTRL_SYSRST_BIT];

   // =======================================================================
   // Button debounce
   // =======================================================================
   assign btn_raw = {RESET_BTN_N, ABORT_BTN_N};

   // edge after debounce.
   // Each button must hold a new level for the full debounce time before
   // the stable copy follows it, so contact bounce is never seen.
   generate
      for (genvar i = 0; i < 2; i++) begin : g_deb
         always_ff @(posedge REF_CLK) begin
            if (SYS_RST) begin
               btn_stable_reg[i] <= 1'b1;
               deb_cnt_reg[i] <= 32'h0000_0000;
            end else if (btn_raw[i] == btn_stable_reg[i]) begin
               deb_cnt_reg[i] <= 32'h0000_0000;
            end else if (deb_cnt_reg[i] >= DEBOUNCE_CYC - 1) begin
               btn_stable_reg[i] <= btn_raw[i];
               deb_cnt_reg[i] <= 32'h0000_0000;
            end else begin
               deb_cnt_reg[i] <= deb_cnt_reg[i] + 32'h0000_0001;
            end
         end
      end
   endgenerate

   // Previous debounced levels for edge detection.
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         abort_prev_reg <= 1'b1;
         reset_prev_reg <= 1'b1;
      end else begin
         abort_prev_reg <= btn_stable_reg[0];
         reset_prev_reg <= btn_stable_reg[1];
      end
   end

   assign abort_press = abort_prev_reg & ~btn_stable_reg[0];
   assign reset_press = reset_prev_reg & ~btn_stable_reg[1];
   assign reset_held = ~btn_stable_reg[1];

   // =======================================================================
   // Abort interrupt
   // =======================================================================
   // abort sets pending.
   // A press sets the pending flag; writing one to it clears it, but a
   // press in the same cycle wins over the clear.
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         abort_pend_reg <= 1'b0;
      end else if (abort_press) begin
         abort_pend_reg <= 1'b1;
      end else if (wb_wr && WB_SEL_I[0] &&
                   {WB_ADR_I[7:2], 2'b00} == `FPC_STATUS_OFS &&
                   WB_DAT_I[`FPC_ST_ABORT_PEND_BIT]) begin
         abort_pend_reg <= 1'b0;
      end
   end

   // interrupt request.
   // The request stays up while the flag is pending and enabled.
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         abort_irq_reg <= 1'b0;
      end else begin
         abort_irq_reg <= abort_pend_reg & ctrl_reg[`FPC_CTRL_ABTEN_BIT];
      end
   end

   // =======================================================================
   // Reset sequencer
   // =======================================================================
   // four reset sources.
   // Power-up, a button press, a watchdog expiry or the software bit each
   // start a reset pulse.
   assign rst_start = power_up_reg | reset_press | WDOG_EXPIRED | sw_rst_req;

   // Remembers that the power-up pulse is still to be issued.
   always_ff @(posedge REF_CLK) begin
      power_up_reg <= SYS_RST;
   end

   // timed board reset.
   // The pulse lasts the reset time, and is extended while the reset
   // button is still held down.
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         rst_state_reg <= fpc_pkg::FPC_RS_IDLE;
         rst_cnt_reg <= 32'h0000_0000;
      end else begin
         case (rst_state_reg)
            fpc_pkg::FPC_RS_IDLE: begin
               if (rst_start) begin
                  rst_state_reg <= fpc_pkg::FPC_RS_PULSE;
                  rst_cnt_reg <= 32'h0000_0000;
               end
            end
            fpc_pkg::FPC_RS_PULSE: begin
               if (rst_start || reset_held) begin
                  rst_cnt_reg <= 32'h0000_0000;
               end else if (rst_cnt_reg >= RST_PULSE_CYC - 1) begin
                  rst_state_reg <= fpc_pkg::FPC_RS_IDLE;
               end else begin
                  rst_cnt_reg <= rst_cnt_reg + 32'h0000_0001;
               end
            end
            default: begin
               rst_state_reg <= fpc_pkg::FPC_RS_IDLE;
            end
         endcase
      end
   end

   // backplane reset gated by role.
   // The onboard reset follows the pulse; the backplane line is pulled
   // low only while this board is system controller.
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         board_rst_reg <= 1'b1;
         sysreset_oe_reg <= 1'b0;
      end else begin
         // The power-up flag bridges the cycle before the pulse state.
         board_rst_reg <= (rst_state_reg == fpc_pkg::FPC_RS_PULSE) |
            power_up_reg;
         sysreset_oe_reg <= (rst_state_reg == fpc_pkg::FPC_RS_PULSE) &
            SYS_CTRL_ROLE;
      end
   end

   // =======================================================================
   // Indicators
   // =======================================================================
   // run activity.
   assign act_raw = {VME_MASTER_CYCLE | VME_SLAVE_ACCESS, SCSI_MASTER,
      LAN_MASTER, LOCAL_CYCLE};

   // stretch activity.
   // Each activity lamp stays on for at least the stretch time after the
   // last cycle it saw, so single short cycles remain visible.
   generate
      for (genvar j = 0; j < `FPC_NUM_ACT; j++) begin : g_act
         always_ff @(posedge REF_CLK) begin
            if (SYS_RST) begin
               act_led_reg[j] <= 1'b0;
               act_cnt_reg[j] <= 32'h0000_0000;
            end else if (act_raw[j]) begin
               act_led_reg[j] <= 1'b1;
               act_cnt_reg[j] <= 32'h0000_0000;
            end else if (act_led_reg[j]) begin
               if (act_cnt_reg[j] >= STRETCH_CYC - 1) begin
                  act_led_reg[j] <= 1'b0;
               end else begin
                  act_cnt_reg[j] <= act_cnt_reg[j] + 32'h0000_0001;
               end
            end
         end
      end
   endgenerate

   // controller lamp.
   // Static lamps follow their conditions one cycle later.
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         fault_led_reg <= 1'b0;
         halt_led_reg <= 1'b0;
         sys_controller_led_led_reg <= 1'b0;
         fuse_led_reg <= 1'b0;
      end else begin
         fault_led_reg <= BOARD_FAULT;
         halt_led_reg <= CPU_HALTED;
         sys_controller_led_led_reg <= SYS_CTRL_ROLE;
         fuse_led_reg <= FUSE_OK;
      end
   end

   // =======================================================================
   // Outputs
   // =======================================================================
   // Every output but SYSRESET_N_O, a constant low, is a flip-flop; the backplane line is open drain.
   assign WB_ACK_O = ack_reg;
   assign WB_DAT_O = rdata_reg;
   assign ABORT_IRQ = abort_irq_reg;
   assign BOARD_RST = board_rst_reg;
   assign SYSRESET_OE = sysreset_oe_reg;
   assign SYSRESET_N_O = 1'b0; // Only ever drives low when enabled.
   assign BOARD_FAULT_LED = fault_led_reg;
   assign CPU_HALT_LED = halt_led_reg;
   assign SYS_CONTROLLER_LED = sys_controller_led_led_reg;
   assign FUSE_LED = fuse_led_reg;
   assign LOCAL_CYCLE_LED = act_led_reg[0];
   assign LAN_LED = act_led_reg[1];
   assign SCSI_LED = act_led_reg[2];
   assign VME_LED = act_led_reg[3];

endmodule // fpc_front_panel

`default_nettype wire

//--- fpc_front_panel_monitor.sv
// Purpose: Port-level checks for the front panel block.
// Assumes: One REF_CLK domain with a synchronous active-high reset.
// Notes: Bound to every instance of the block.
`timescale 1ns/10ps
`default_nettype none
// ====================
// Checker
// ====================
module fpc_front_panel_monitor #(
   parameter int unsigned DEBOUNCE_CYC = 4,
   parameter int unsigned RST_PULSE_CYC = 8,
   parameter int unsigned STRETCH_CYC = 4
) (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_ACK_O,
   input wire logic ABORT_BTN_N,
   input wire logic RESET_BTN_N,
   input wire logic SYS_CTRL_ROLE,
   input wire logic BOARD_FAULT,
   input wire logic LOCAL_CYCLE,
   input wire logic LAN_MASTER,
   input wire logic ABORT_IRQ,
   input wire logic BOARD_RST,
   input wire logic SYSRESET_OE,
   input wire logic BOARD_FAULT_LED,
   input wire logic LOCAL_CYCLE_LED,
   input wire logic LAN_LED
);
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (SYS_RST);
   // Bus answer timing, LED behaviour, the reset button and the backplane reset.
   AST_ACK_NEXT: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=>
      WB_ACK_O) else $error("Request not acknowledged next cycle.");
   AST_ACK_ONE: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("Acknowledge held over one cycle.");
   AST_FAULT_LED: assert property (1'b1 |=>
      BOARD_FAULT_LED == $past(BOARD_FAULT)) else $error("Fault LED wrong.");
   AST_RUN_STRETCH: assert property ($fell(LOCAL_CYCLE) |->
      LOCAL_CYCLE_LED [*3]) else $error("Run LED not stretched.");
   AST_LAN_OFF: assert property (!LAN_MASTER [*8] |-> !LAN_LED)
      else $error("LAN LED stuck on.");
   AST_ABORT_IRQ: assert property ($fell(ABORT_BTN_N) ##1
      !ABORT_BTN_N [*8] |-> ##[0:4] ABORT_IRQ) else $error("No abort irq.");
   AST_RST_BTN: assert property (!RESET_BTN_N [*8] |=> BOARD_RST)
      else $error("Reset button did not reset board.");
   AST_SYSRST_ROLE: assert property (SYSRESET_OE |->
      SYS_CTRL_ROLE || $past(SYS_CTRL_ROLE)) else $error("Stray SYSRESET.");
   AST_SYSRST_ON: assert property (BOARD_RST && SYS_CTRL_ROLE &&
      $past(SYS_CTRL_ROLE) && !$past(SYS_RST, 2) |-> SYSRESET_OE)
      else $error("SYSRESET not driven during reset.");
   // Main scenarios reached.
   cover property (ABORT_IRQ);
   cover property (SYSRESET_OE);
   cover property ($fell(LAN_LED));
endmodule // fpc_front_panel_monitor

bind fpc_front_panel fpc_front_panel_monitor #(.DEBOUNCE_CYC(DEBOUNCE_CYC),
   .RST_PULSE_CYC(RST_PULSE_CYC), .STRETCH_CYC(STRETCH_CYC)) mon (
   .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .ABORT_BTN_N(ABORT_BTN_N),
   .RESET_BTN_N(RESET_BTN_N), .SYS_CTRL_ROLE(SYS_CTRL_ROLE),
   .BOARD_FAULT(BOARD_FAULT), .LOCAL_CYCLE(LOCAL_CYCLE),
   .LAN_MASTER(LAN_MASTER), .ABORT_IRQ(ABORT_IRQ), .BOARD_RST(BOARD_RST),
   .SYSRESET_OE(SYSRESET_OE), .BOARD_FAULT_LED(BOARD_FAULT_LED),
   .LOCAL_CYCLE_LED(LOCAL_CYCLE_LED), .LAN_LED(LAN_LED));
`default_nettype wire

//--- fpc_front_panel_tb_top.sv
// Purpose: Self-checking bench for the front panel block.
// Assumes: Short debounce, pulse and stretch counts.
// Notes: Plain LED cases run from a table.
`timescale 1ns/10ps
`default_nettype none
// ====================
// Bench
// ====================
module fpc_front_panel_tb_top;
   logic clk, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic abt_n = 1'b1, rbt_n = 1'b1, role = 1'b1, wdog = 1'b0;
   logic fault = 1'b0, halt = 1'b0, fuse = 1'b0;
   logic ack, irq, brst, srn, soe, wire_n;
   logic [4:0] act = 5'h00;
   logic [7:0] adr = 8'h00;
   logic [7:0] irq_events;
   logic [31:0] wdat = 32'h0, rdat, q;
   wire [7:0] leds;
   int miscompares = 0;
   int cmp_count = 0;
   int cycles = 0;
   logic [3:0] row_in [5] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h0};
   logic [7:0] row_exp [5] = '{8'h01, 8'h02, 8'h08, 8'h20, 8'h00};
   logic [7:0] act_led [5] = '{8'h04, 8'h10, 8'h40, 8'h80, 8'h80};

   fpc_front_panel #(.DEBOUNCE_CYC(4), .RST_PULSE_CYC(8),
      .STRETCH_CYC(4)) uut (
      .REF_CLK(clk), .SYS_RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat),
      .WB_DAT_O(rdat), .WB_ACK_O(ack), .ABORT_BTN_N(abt_n),
      .RESET_BTN_N(rbt_n), .SYS_CTRL_ROLE(role), .WDOG_EXPIRED(wdog),
      .BOARD_FAULT(fault), .CPU_HALTED(halt), .LOCAL_CYCLE(act[0]),
      .LAN_MASTER(act[1]), .SCSI_MASTER(act[2]),
      .VME_MASTER_CYCLE(act[3]), .VME_SLAVE_ACCESS(act[4]),
      .FUSE_OK(fuse), .ABORT_IRQ(irq), .BOARD_RST(brst),
      .SYSRESET_N_O(srn), .SYSRESET_OE(soe), .BOARD_FAULT_LED(leds[0]),
      .CPU_HALT_LED(leds[1]), .LOCAL_CYCLE_LED(leds[2]),
      .SYS_CONTROLLER_LED(leds[3]), .LAN_LED(leds[4]), .FUSE_LED(leds[5]),
      .SCSI_LED(leds[6]), .VME_LED(leds[7]));

   fpc_backplane_model bp (.clk(clk), .rst(rst), .sysreset_n_o(srn),
      .sysreset_oe(soe), .abort_irq(irq), .sysreset_wire_n(wire_n),
      .irq_events(irq_events));

   // Free-running 250 MHz clock.
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Compares one value and counts it.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One classic bus cycle; read data lands in q.
   task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      chk(n, 32'h2);
   endtask

   // Waits a bounded time for the board reset to end.
   task automatic wait_idle();
      int n;
      n = 0;
      while (brst !== 1'b0 && n < 100) begin
         @(posedge clk);
         n++;
      end
      chk(brst, 1'b0);
   endtask

   task automatic done(input string s);
      $display("test %s done", s);
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Cuts a hung run short.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         miscompares++;
         final_report();
      end
   end

   // Main sequence.
   initial begin
      int i;
      repeat (5) @(posedge clk);
      chk({brst, ack, leds}, 10'h200);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      chk(brst, 1'b1);
      @(posedge clk);
      chk({brst, soe, wire_n}, 3'b110);
      wait_idle();
      wb(1'b0, 8'h00, 32'h0);
      chk(q, 32'h2);
      wb(1'b0, 8'h04, 32'h0);
      chk(q, 32'h0804);
      done("reset");
      for (i = 0; i < 5; i++) begin
         {fault, halt, role, fuse} <= row_in[i];
         repeat (3) @(posedge clk);
         chk(leds, row_exp[i]);
         wb(1'b0, 8'h04, 32'h0);
         chk(q[15:8], row_exp[i]);
      end
      done("table");
      for (i = 0; i < 5; i++) begin
         act <= 5'h01 << i;
         @(posedge clk);
         act <= 5'h00;
         repeat (3) @(posedge clk);
         chk(leds, act_led[i]);
         repeat (10) @(posedge clk);
         chk(leds, 8'h00);
      end
      done("activity");
      for (i = 0; i < 3; i++) begin
         abt_n <= 1'b0;
         repeat (2) @(posedge clk);
         abt_n <= 1'b1;
         repeat (2) @(posedge clk);
      end
      repeat (8) @(posedge clk);
      chk({irq, irq_events}, 9'h000);
      abt_n <= 1'b0;
      repeat (12) @(posedge clk);
      abt_n <= 1'b1;
      @(posedge clk);
      abt_n <= 1'b0;
      @(posedge clk);
      abt_n <= 1'b1;
      repeat (10) @(posedge clk);
      chk({irq, irq_events}, 9'h101);
      wb(1'b0, 8'h04, 32'h0);
      chk(q[1:0], 2'b01);
      wb(1'b1, 8'h00, 32'h0);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      wb(1'b1, 8'h00, 32'h2);
      repeat (2) @(posedge clk);
      chk(irq, 1'b1);
      wb(1'b1, 8'h04, 32'h1);
      repeat (2) @(posedge clk);
      chk({irq, irq_events}, 9'h002);
      done("abort");
      rbt_n <= 1'b0;
      repeat (10) @(posedge clk);
      chk({brst, soe, wire_n}, 3'b101);
      wb(1'b0, 8'h04, 32'h0);
      chk(q[3:0], 4'h8);
      rbt_n <= 1'b1;
      wait_idle();
      role <= 1'b1;
      repeat (2) @(posedge clk);
      rbt_n <= 1'b0;
      repeat (10) @(posedge clk);
      chk({brst, soe, wire_n}, 3'b110);
      rbt_n <= 1'b1;
      wait_idle();
      done("reset button");
      wdog <= 1'b1;
      @(posedge clk);
      wdog <= 1'b0;
      repeat (4) @(posedge clk);
      chk({brst, wire_n}, 2'b10);
      wait_idle();
      wb(1'b1, 8'h00, 32'h3);
      repeat (4) @(posedge clk);
      chk({brst, wire_n}, 2'b10);
      wait_idle();
      wb(1'b0, 8'h00, 32'h0);
      chk(q, 32'h2);
      wb(1'b1, 8'h10, 32'hff);
      wb(1'b0, 8'h10, 32'h0);
      chk(q, 32'h0);
      done("sources");
      final_report();
   end
endmodule // fpc_front_panel_tb_top
`default_nettype wire

//--- fpc_pkg.sv
// Purpose: Types shared by the front panel control block.
// Assumes: Nothing beyond the defines header.
// Notes: Holds the reset sequencer state type.
`default_nettype none

// ==========================================================================
// Package
// ==========================================================================
package fpc_pkg;
   // Reset sequencer states.
   typedef enum logic [0:0] {
      FPC_RS_IDLE = 1'b0,
      FPC_RS_PULSE = 1'b1
   } fpc_rst_state_e;
endpackage

`default_nettype wire
